// File: logic/dawd_host.sv
// Controller end: APB registers and the per-scan output word writer.
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none

module dawd_host
   import dawd_pkg::*;
#(
   parameter int SCAN_CYC = SCAN_CYCLES
)(
   input  wire logic              ref_clk_in,
   input  wire logic              resetn_in,
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [ADDR_W-1:0] paddr_in,
   input  wire logic [DATA_W-1:0] pwdata_in,
   output logic      [DATA_W-1:0] prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   dawd_link_if.ctrl              link
);
   if (SCAN_CYC < 8) begin : g_chk
      $error("dawd_host: scan period too short for one scan");
   end

   // ------------------------------------------------------------
   // Conversion helpers
   // ------------------------------------------------------------
   function automatic logic [13:0] bcd_to_bin(input logic [15:0] b);
      logic [13:0] r;
      r = 14'(b[15:12]) * 14'd1000 + 14'(b[11:8]) * 14'd100
        + 14'(b[7:4]) * 14'd10 + 14'(b[3:0]);
      return r;
   endfunction

   // Magnitudes are clamped so the word never wraps at the decoder.
   function automatic logic [WORD_W-1:0] make_word(
      input logic [CHV_W-1:0] v, input logic bcd, input logic sgn,
      input logic [1:0]       sel_n);
      logic [13:0]       m;
      logic [CODE_W-1:0] c;
      m = bcd ? bcd_to_bin(v[15:0]) : v[13:0];
      if (sgn) begin
         c = (m > 14'(SIGNED_MAX)) ? SIGNED_MAX : m[CODE_W-1:0];
      end else begin
         c = (m > 14'(CODE_MAX)) ? CODE_MAX : m[CODE_W-1:0];
      end
      return {(sgn & v[CHV_NEG_BIT]), 1'b0, sel_n, c};
   endfunction

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   logic [CTRL_W-1:0] ctrl_q;
   logic [CHV_W-1:0]  ch1_q;
   logic [CHV_W-1:0]  ch2_q;
   logic [DATA_W-1:0] prdata_q;
   logic              pready_q;
   logic              pslverr_q;
   logic [SCAN_CNT_W-1:0] scan_cnt_q;
   logic              busy;
   logic              setup;
   logic              wr_done;
   logic              hit;
   logic [DATA_W-1:0] rd_mux;

   assign setup   = psel_in & ~penable_in;
   assign wr_done = psel_in & penable_in & pready_q & pwrite_in;
   assign hit     = (paddr_in == CTRL_OFS) | (paddr_in == CH1_OFS)
                  | (paddr_in == CH2_OFS)  | (paddr_in == STATUS_OFS);
   assign rd_mux  = (paddr_in == CTRL_OFS) ? DATA_W'(ctrl_q)
                  : (paddr_in == CH1_OFS)  ? DATA_W'(ch1_q)
                  : (paddr_in == CH2_OFS)  ? DATA_W'(ch2_q)
                  : (paddr_in == STATUS_OFS)
                    ? DATA_W'({busy, scan_cnt_q}) : '0;

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~hit;
         prdata_q  <= (setup & ~pwrite_in) ? rd_mux : '0;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         ctrl_q <= CTRL_RESET;
         ch1_q  <= '0;
         ch2_q  <= '0;
      end else if (wr_done) begin
         if (paddr_in == CTRL_OFS) ctrl_q <= pwdata_in[CTRL_W-1:0];
         if (paddr_in == CH1_OFS)  ch1_q  <= pwdata_in[CHV_W-1:0];
         if (paddr_in == CH2_OFS)  ch2_q  <= pwdata_in[CHV_W-1:0];
      end
   end

   assign prdata_out  = prdata_q;
   assign pready_out  = pready_q;
   assign pslverr_out = pslverr_q;

   // ------------------------------------------------------------
   // Scan sequencer
   // ------------------------------------------------------------
   dawd_state_t       state_q;
   logic [31:0]       timer_q;
   logic              alt_q;
   logic              both;
   logic [1:0]        sel1_n;
   logic [WORD_W-1:0] w1;
   logic [WORD_W-1:0] w2;
   logic              start_q;
   logic              valid_q;
   logic              end_q;
   logic [WORD_W-1:0] word_q;

   // Remote placement cannot use the pointer method at all.
   assign both   = ctrl_q[CTRL_PTR_BIT] & ~ctrl_q[CTRL_REMOTE_BIT];
   assign sel1_n = (both | ~alt_q) ? 2'b10 : 2'b01;
   assign w1 = make_word(sel1_n[0] ? ch2_q : ch1_q, ctrl_q[CTRL_BCD_BIT],
                         ~ctrl_q[CTRL_FMT_LSB + (sel1_n[0] ? 1 : 0)], sel1_n);
   assign w2 = make_word(ch2_q, ctrl_q[CTRL_BCD_BIT],
                         ~ctrl_q[CTRL_FMT_LSB + 1], 2'b01);
   assign busy = (state_q != DAWD_IDLE);

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         state_q    <= DAWD_IDLE;
         timer_q    <= '0;
         alt_q      <= 1'b0;
         scan_cnt_q <= '0;
         start_q    <= 1'b0;
         valid_q    <= 1'b0;
         end_q      <= 1'b0;
         word_q     <= '0;
      end else begin
         start_q <= 1'b0;
         valid_q <= 1'b0;
         end_q   <= 1'b0;
         unique case (state_q)
            DAWD_IDLE: begin
               if (timer_q >= 32'(SCAN_CYC - 1)) begin
                  timer_q <= '0;
                  if (ctrl_q[CTRL_EN_BIT]) begin
                     state_q <= DAWD_START;
                     start_q <= 1'b1;
                  end
               end else begin
                  timer_q <= timer_q + 32'd1;
               end
            end
            DAWD_START: begin
               state_q <= both ? DAWD_WORD2 : DAWD_END;
               valid_q <= 1'b1;
               word_q  <= w1;
            end
            DAWD_WORD2: begin
               state_q <= DAWD_END;
               valid_q <= 1'b1;
               word_q  <= w2;
            end
            DAWD_END: begin
               state_q    <= DAWD_IDLE;
               end_q      <= 1'b1;
               alt_q      <= ~alt_q;
               scan_cnt_q <= scan_cnt_q + SCAN_CNT_W'(1);
            end
            default: state_q <= DAWD_IDLE;
         endcase
      end
   end

   assign link.scan_start = start_q;
   assign link.word_valid = valid_q;
   assign link.word       = word_q;
   assign link.scan_end   = end_q;

endmodule

`default_nettype wire

// File: logic/dawd_pkg.sv
// Shared constants for the two-channel output word decoder and its controller.
package dawd_pkg;

   // ------------------------------------------------------------
   // Output word layout
   // ------------------------------------------------------------
   localparam int WORD_W       = 16;
   localparam int CODE_W       = 12;
   localparam int MAG_W        = 11;
   localparam int HELD_W       = CODE_W + 1;
   localparam int NUM_CHANNELS = 2;
   localparam int SEL1_BIT     = 12;
   localparam int SEL2_BIT     = 13;
   localparam int SPARE_BIT    = 14;
   localparam int SIGN_BIT     = 15;
   localparam logic [CODE_W-1:0] CODE_MAX     = 12'hfff;
   localparam logic [CODE_W-1:0] CODE_MID     = 12'h800;
   localparam logic [CODE_W-1:0] SIGNED_MAX   = 12'h7ff;
   localparam logic [WORD_W-1:0] SIGN_OR_MASK = 16'h8000;

   // ------------------------------------------------------------
   // Controller register map (APB, byte addresses)
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
   localparam logic [ADDR_W-1:0] CH1_OFS    = 8'h04;
   localparam logic [ADDR_W-1:0] CH2_OFS    = 8'h08;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0c;
   localparam int CTRL_EN_BIT     = 0;
   localparam int CTRL_PTR_BIT    = 1;
   localparam int CTRL_REMOTE_BIT = 2;
   localparam int CTRL_BCD_BIT    = 3;
   localparam int CTRL_FMT_LSB    = 4;
   localparam int CTRL_W          = 6;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
   localparam int CHV_NEG_BIT     = 16;
   localparam int CHV_W           = 17;
   localparam int STAT_BUSY_BIT   = 16;
   localparam int SCAN_CNT_W      = 16;

   // ------------------------------------------------------------
   // Scan timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ        = 25;
   localparam int SCAN_PERIOD_US = 1000;
   localparam int SCAN_CYCLES    = SCAN_PERIOD_US * CLK_MHZ;

   typedef enum logic [2:0] {
      DAWD_IDLE, DAWD_START, DAWD_WORD1, DAWD_WORD2, DAWD_END
   } dawd_state_t;

endpackage

// File: logic/dawd_link_if.sv
// Scan-synchronous output image link between controller and decoder.
`timescale 1ns/1ns
`default_nettype none

interface dawd_link_if
   import dawd_pkg::*;
(
   input wire logic clk
);
   logic              scan_start;
   logic              word_valid;
   logic [WORD_W-1:0] word;
   logic              scan_end;

   modport ctrl (
      input  clk,
      output scan_start,
      output word_valid,
      output word,
      output scan_end
   );

   modport dev (
      input clk,
      input scan_start,
      input word_valid,
      input word,
      input scan_end
   );
endinterface

`default_nettype wire

// File: logic/dawd_chan_hold.sv
// One channel's held sign and magnitude, loaded only when selected.
`timescale 1ns/1ns
`default_nettype none

module dawd_chan_hold
   import dawd_pkg::*;
#(
   parameter int W = HELD_W
)(
   input  wire logic         ref_clk_in,
   input  wire logic         resetn_in,
   input  wire logic         load_in,
   input  wire logic [W-1:0] value_in,
   output logic      [W-1:0] value_out
);
   if (W < 2) begin : g_chk
      $error("dawd_chan_hold: width too small");
   end

   logic [W-1:0] value_q;

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         value_q <= '0;
      end else if (load_in) begin
         value_q <= value_in;
      end
   end

   assign value_out = value_q;
endmodule

`default_nettype wire

// File: logic/dawd_device.sv
// Device end: decodes scan words into two held 12-bit channel codes.
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// ------------------------------------------------------------

module dawd_device
   import dawd_pkg::*;
#(
   parameter int CHANNELS = NUM_CHANNELS
)(
   input  wire logic                             ref_clk_in,
   input  wire logic                             resetn_in,
   dawd_link_if.dev                              link,
   input  wire logic [CHANNELS-1:0]              unsigned_format_setting_in,
   output logic      [CHANNELS-1:0][CODE_W-1:0]  chan_code_out,
   output logic                                  refresh_out,
   output logic      [CHANNELS-1:0]              updated_out,
   output logic      [SCAN_CNT_W-1:0]            scan_count_out,
   output logic                                  stray_word_out
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (CHANNELS != NUM_CHANNELS) begin : g_chk
      $error("dawd_device: the word carries exactly two selects");
   end

   // ------------------------------------------------------------
   // Code conversion
   // ------------------------------------------------------------
   // Signed data is offset about mid-scale with no saturation, so a
   // positive magnitude past 2047 wraps round to the bottom code.
   function automatic logic [CODE_W-1:0] to_code(
      input logic              fmt_unsigned,
      input logic [HELD_W-1:0] held
   );
      logic              neg;
      logic [CODE_W-1:0] mag;
      logic [CODE_W-1:0] code;
      neg = held[CODE_W];
      mag = held[CODE_W-1:0];
      if (fmt_unsigned) begin
         code = mag;
      end else if (neg) begin
         code = CODE_MID - mag;
      end else begin
         code = CODE_MID + mag;
      end
      return code;
   endfunction

   // ------------------------------------------------------------
   // Word decode
   // ------------------------------------------------------------
   logic [WORD_W-1:0]   word;
   logic                word_valid;
   logic                scan_start;
   logic                scan_end;
   logic [CHANNELS-1:0] sel_n;
   logic                sign_point;
   logic [CODE_W-1:0]   magnitude;
   logic [HELD_W-1:0]   held_in;
   logic                in_scan_q;
   logic                in_scan_d;
   logic                word_ok;
   logic                stray;
   logic [CHANNELS-1:0] load;

   assign word       = link.word;
   assign word_valid = link.word_valid;
   assign scan_start = link.scan_start;
   assign scan_end   = link.scan_end;

   // Bit 14 is never looked at, whatever the controller puts there.
   assign sel_n      = {word[SEL2_BIT], word[SEL1_BIT]};
   assign sign_point = word[SIGN_BIT];
   assign magnitude  = word[CODE_W-1:0];
   assign held_in    = {sign_point, magnitude};

   // A word counts only between the scan's start and end marks.
   assign word_ok = word_valid & (in_scan_q | scan_start);
   assign stray   = word_valid & ~word_ok;

   // Low select loads its channel; both high loads neither.
   assign load = {CHANNELS{word_ok}} & ~sel_n;

   assign in_scan_d = scan_start | (in_scan_q & ~scan_end);

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         in_scan_q <= 1'b0;
      end else begin
         in_scan_q <= in_scan_d;
      end
   end

   // ------------------------------------------------------------
   // Channel holding registers
   // ------------------------------------------------------------
   logic [CHANNELS-1:0][HELD_W-1:0] held;
   logic [CHANNELS-1:0][HELD_W-1:0] held_now;
   logic [CHANNELS-1:0][CODE_W-1:0] code_d;

   for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
      dawd_chan_hold #(
         .W (HELD_W)
      ) u_hold (
         .ref_clk_in (ref_clk_in),
         .resetn_in  (resetn_in),
         .load_in    (load[i]),
         .value_in   (held_in),
         .value_out  (held[i])
      );

      // A word arriving with the end mark is still part of that scan.
      assign held_now[i] = load[i] ? held_in : held[i];
      assign code_d[i]   = to_code(unsigned_format_setting_in[i],
                                   held_now[i]);
   end

   // ------------------------------------------------------------
   // Per-scan refresh
   // ------------------------------------------------------------
   // Both outputs are refreshed at every scan end, new data or not,
   // so an unselected channel simply repeats its held code.
   logic [CHANNELS-1:0][CODE_W-1:0] code_q;
   logic                            refresh_q;
   logic [CHANNELS-1:0]             upd_q;
   logic [CHANNELS-1:0]             upd_d;
   logic [CHANNELS-1:0]             updated_q;
   logic [SCAN_CNT_W-1:0]           scan_cnt_q;
   logic                            stray_q;

   // A fresh start mark begins a new tally; loads in that cycle count.
   assign upd_d = scan_start ? load : (upd_q | load);

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         upd_q <= '0;
      end else if (scan_end) begin
         upd_q <= '0;
      end else begin
         upd_q <= upd_d;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         code_q    <= '0;
         updated_q <= '0;
      end else if (scan_end) begin
         code_q    <= code_d;
         updated_q <= upd_d;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         refresh_q  <= 1'b0;
         scan_cnt_q <= '0;
      end else begin
         refresh_q  <= scan_end;
         scan_cnt_q <= scan_cnt_q + SCAN_CNT_W'(scan_end);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         stray_q <= 1'b0;
      end else begin
         stray_q <= stray;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // The code spans 0 to 4095 over the channel's configured range.
   assign chan_code_out  = code_q;
   assign refresh_out    = refresh_q;
   assign updated_out    = updated_q;
   assign scan_count_out = scan_cnt_q;
   assign stray_word_out = stray_q;

endmodule

`default_nettype wire

// File: verification/dawd_link_props.sv
// Link and channel output checker for the two-channel output word decoder.
`timescale 1ns/1ns
`default_nettype none

module dawd_link_props
   import dawd_pkg::*;
(
   input wire logic                    clk,
   input wire logic                    resetn_in,
   input wire logic                    scan_start,
   input wire logic                    word_valid,
   input wire logic [WORD_W-1:0]       word,
   input wire logic                    scan_end,
   input wire logic [1:0]              unsigned_format_setting_in,
   input wire logic [1:0][CODE_W-1:0]  chan_code_out,
   input wire logic                    refresh_out,
   input wire logic [1:0]              updated_out,
   input wire logic                    stray_word_out
);
   // ------------------------------------------------------------
   // Reference copy of what each channel should hold
   // ------------------------------------------------------------
   // Sign and magnitude are kept rather than the code, since the format pins may move while a channel sits idle.
   logic [1:0][HELD_W-1:0] held_q;
   logic [1:0]             seen_q;
   wire logic [1:0]        pick = {~word[SEL2_BIT], ~word[SEL1_BIT]} & {2{word_valid}};

   function automatic logic [CODE_W-1:0] code_of(input logic uns, input logic [HELD_W-1:0] h);
      return uns ? h[CODE_W-1:0] : (h[CODE_W] ? CODE_MID - h[CODE_W-1:0] : CODE_MID + h[CODE_W-1:0]);
   endfunction

   always_ff @(posedge clk) begin
      if (!resetn_in) begin
         held_q <= '0;
         seen_q <= '0;
      end else begin
         seen_q <= (scan_start ? 2'b00 : seen_q) | pick;
         for (int i = 0; i < 2; i++) begin
            if (pick[i]) begin
               held_q[i] <= {word[SIGN_BIT], word[CODE_W-1:0]};
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn_in);

   sequence one_word_s;
      word_valid ##1 scan_end;
   endsequence
   sequence two_words_s;
      word_valid ##1 word_valid ##1 scan_end;
   endsequence

   scan_frame_a: assert property (scan_start |=> (one_word_s or two_words_s))
      else $error("scan frame is malformed");
   scan_gap_a: assert property (scan_start |=> !scan_start [*8])
      else $error("scans start too close together");
   refresh_next_a: assert property (scan_end |=> refresh_out)
      else $error("no refresh after scan end");
   refresh_cause_a: assert property (refresh_out |-> $past(scan_end))
      else $error("refresh without scan end");
   code_hold_a: assert property (!refresh_out |-> $stable(chan_code_out))
      else $error("channel code moved outside a refresh");
   update_hold_a: assert property (!refresh_out |-> $stable(updated_out))
      else $error("update flags moved outside a refresh");
   update_match_a: assert property (refresh_out |-> updated_out == seen_q)
      else $error("update flags differ from selected channels");
   code_one_a: assert property (
      refresh_out |-> chan_code_out[0] == code_of(unsigned_format_setting_in[0], held_q[0]))
      else $error("channel one code wrong");
   code_two_a: assert property (
      refresh_out |-> chan_code_out[1] == code_of(unsigned_format_setting_in[1], held_q[1]))
      else $error("channel two code wrong");
   no_stray_a: assert property (!stray_word_out)
      else $error("word seen outside a scan");
endmodule

`default_nettype wire

// File: verification/test_dual_channel_dac_word_decoder.sv
// Self-checking bench for the output word decoder and its controller.
`timescale 1ns/1ns
`default_nettype none

module test_dual_channel_dac_word_decoder
   import dawd_pkg::*;
;
   logic                    ref_clk_in, resetn_in, psel, penable, pwrite;
   logic [ADDR_W-1:0]       paddr;
   logic [DATA_W-1:0]       pwdata, prdata, rd;
   logic                    pready, pslverr, err, refresh, stray;
   logic [1:0]              fmt, updated;
   logic [1:0][CODE_W-1:0]  code;
   logic [SCAN_CNT_W-1:0]   scan_count;
   int                      failures, check_count, n_ref, base;

   dawd_link_if link_inst (.clk(ref_clk_in));

   dawd_host #(.SCAN_CYC(16)) dawd_host_inst (
      .ref_clk_in  (ref_clk_in),
      .resetn_in   (resetn_in),
      .psel_in     (psel),
      .penable_in  (penable),
      .pwrite_in   (pwrite),
      .paddr_in    (paddr),
      .pwdata_in   (pwdata),
      .prdata_out  (prdata),
      .pready_out  (pready),
      .pslverr_out (pslverr),
      .link        (link_inst)
   );

   dawd_device dawd_device_inst (
      .ref_clk_in                 (ref_clk_in),
      .resetn_in                  (resetn_in),
      .link                       (link_inst),
      .unsigned_format_setting_in (fmt),
      .chan_code_out              (code),
      .refresh_out                (refresh),
      .updated_out                (updated),
      .scan_count_out             (scan_count),
      .stray_word_out             (stray)
   );

   dawd_link_props props_inst (
      .clk                        (link_inst.clk),
      .resetn_in                  (resetn_in),
      .scan_start                 (link_inst.scan_start),
      .word_valid                 (link_inst.word_valid),
      .word                       (link_inst.word),
      .scan_end                   (link_inst.scan_end),
      .unsigned_format_setting_in (fmt),
      .chan_code_out              (code),
      .refresh_out                (refresh),
      .updated_out                (updated),
      .stray_word_out             (stray)
   );

   initial begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end

   always @(posedge ref_clk_in) begin
      if (resetn_in === 1'b1 && refresh === 1'b1) begin
         n_ref++;
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      @(posedge ref_clk_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_in);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         chk("apb ready", 32'h1, {31'h0, pready});
         test_done();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_refresh();
      for (int n = 0; n < 200; n++) begin
         @(posedge ref_clk_in);
         if (refresh === 1'b1) return;
      end
      chk("refresh", 32'h1, 32'h0);
      test_done();
   endtask

   // Software side hands binary or four-digit decimal; the host clamps before sending.
   // A binary value is taken from the low fourteen bits of the register only.
   function automatic logic [CODE_W-1:0] exp_code(input logic uns, input logic bcd, input logic [16:0] v);
      int b;
      int m;
      b = bcd ? v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0] : int'(v[13:0]);
      if (uns) return (b > 4095) ? 12'hfff : 12'(b);
      m = (b > 2047) ? 2047 : b;
      return v[16] ? 12'(2048 - m) : 12'(2048 + m);
   endfunction

   // The host is stopped before the format pins move, so no scan straddles the change.
   task automatic run_case(input logic ptr, input logic rem, input logic bcd, input logic [1:0] uns,
                           input logic [16:0] v1, input logic [16:0] v2);
      apb(1'b1, CTRL_OFS, 32'h0);
      repeat (8) @(posedge ref_clk_in);
      fmt <= uns;
      apb(1'b1, CH1_OFS, {15'h0, v1});
      apb(1'b1, CH2_OFS, {15'h0, v2});
      // A set format bit in the control word marks that channel as unsigned.
      apb(1'b1, CTRL_OFS, {26'h0, uns, bcd, rem, ptr, 1'b1});
      repeat (3) wait_refresh();
      chk("chan 1 code", {20'h0, exp_code(uns[0], bcd, v1)}, {20'h0, code[0]});
      chk("chan 2 code", {20'h0, exp_code(uns[1], bcd, v2)}, {20'h0, code[1]});
      if (ptr && !rem) begin
         chk("both updated", 32'h3, {30'h0, updated});
      end else begin
         chk("one updated", 32'h1, {31'h0, updated === 2'b01 || updated === 2'b10});
      end
      $display("case done ptr=%0d remote=%0d bcd=%0d fmt=%b", ptr, rem, bcd, uns);
   endtask

   initial begin
      resetn_in = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      fmt = 2'b11;
      failures = 0;
      check_count = 0;
      n_ref = 0;
      void'($urandom(32'h30d5693d));
      repeat (3) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      chk("reset codes", 32'h0, {8'h0, code});
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl reset", 32'h0, rd);
      apb(1'b1, STATUS_OFS, 32'hffff_ffff);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk("status read only", 32'h0, rd);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      $display("register test done");
      run_case(1'b1, 1'b0, 1'b0, 2'b11, 17'h00000, 17'h00fff);
      run_case(1'b1, 1'b0, 1'b0, 2'b00, 17'h107ff, 17'h007ff);
      run_case(1'b1, 1'b0, 1'b1, 2'b11, 17'h01234, 17'h09999);
      run_case(1'b0, 1'b0, 1'b0, 2'b01, 17'h01388, 17'h10064);
      run_case(1'b1, 1'b1, 1'b0, 2'b10, 17'h10400, 17'h00abc);
      for (int i = 0; i < 12; i++) begin
         run_case(1'($urandom_range(1, 0)), 1'($urandom_range(1, 0)), 1'b0, 2'($urandom_range(3, 0)),
                  17'($urandom_range(17'h1ffff, 0)), 17'($urandom_range(17'h1ffff, 0)));
      end
      apb(1'b1, CTRL_OFS, 32'h0);
      repeat (8) @(posedge ref_clk_in);
      base = n_ref;
      repeat (60) @(posedge ref_clk_in);
      chk("idle refreshes", base, n_ref);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk("status count", n_ref & 32'hffff, {16'h0, rd[15:0]});
      chk("count output", n_ref & 32'hffff, {16'h0, scan_count});
      $display("idle test done");
      test_done();
   end
endmodule

`default_nettype wire
